// >>> hdl/bal_pkg.sv
package bal_pkg;
    localparam int DATA_W   = 8;
    localparam int PTR_W    = 16;
    localparam int LIT6_W   = 6;
    localparam int FADDR_W  = 7;
    localparam int NIB_W    = 4;
    localparam int MSB      = 7;
    localparam logic [7:0]  ACC_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;

    typedef enum logic [2:0] {
        BAL_OP_NONE,
        BAL_OP_POINTER_ADD,
        BAL_OP_LITERAL_AND,
        BAL_OP_LITERAL_ADD,
        BAL_OP_REGISTER_AND,
        BAL_OP_REGISTER_ADD,
        BAL_OP_ARITH_SHIFT
    } bal_op_t;

    typedef struct packed {
        bal_op_t                op;
        logic [7:0]             literal;
        logic                   ptr_sel;
        logic [FADDR_W-1:0]     faddr;
        logic                   dest;
    } bal_cmd_t;

    typedef struct packed {
        logic c;
        logic dc;
        logic z;
    } bal_flags_t;
endpackage

// >>> hdl/bal_adder.sv
module bal_adder #(
    parameter int W = 8
) (
    // Operands
    input  wire logic [W-1:0] i_a,
    input  wire logic [W-1:0] i_b,
    // Result
    output logic      [W-1:0] o_sum,
    output logic              o_carry,
    output logic              o_half_carry
) ;
    logic [W:0]                   full;
    logic [bal_pkg::NIB_W:0]      low;

    assign full         = {1'b0, i_a} + {1'b0, i_b};
    assign low          = {1'b0, i_a[bal_pkg::NIB_W-1:0]} + {1'b0, i_b[bal_pkg::NIB_W-1:0]};
    assign o_sum        = full[W-1:0];
    assign o_carry      = full[W];
    assign o_half_carry = low[bal_pkg::NIB_W];
endmodule

// >>> hdl/bal_alu.sv
module bal_alu (
    // Clock and reset
    input  wire logic                              i_sys_clk,
    input  wire logic                              i_rst,
    // Command
    input  wire logic                              i_valid,
    input  wire bal_pkg::bal_cmd_t                 i_cmd,
    // Addressed file register read data
    input  wire logic [bal_pkg::DATA_W-1:0]        i_file_rdata,
    // File register write back
    output logic                                   o_file_we,
    output logic      [bal_pkg::FADDR_W-1:0]       o_file_waddr,
    output logic      [bal_pkg::DATA_W-1:0]        o_file_wdata,
    // Architectural state
    output logic      [bal_pkg::DATA_W-1:0]        o_acc,
    output bal_pkg::bal_flags_t                    o_flags,
    output logic      [bal_pkg::PTR_W-1:0]         o_ptr0,
    output logic      [bal_pkg::PTR_W-1:0]         o_ptr1
);
    logic [bal_pkg::DATA_W-1:0] acc;
    bal_pkg::bal_flags_t        flags;
    logic [bal_pkg::PTR_W-1:0]  ptr [2];
    logic                       file_we;
    logic [bal_pkg::FADDR_W-1:0] file_waddr;
    logic [bal_pkg::DATA_W-1:0] file_wdata;

    wire bal_pkg::bal_op_t op = i_valid ? i_cmd.op : bal_pkg::BAL_OP_NONE;

    // Operand B is the literal or the file register
    wire logic is_lit = (op == bal_pkg::BAL_OP_LITERAL_AND) || (op == bal_pkg::BAL_OP_LITERAL_ADD);
    wire logic [bal_pkg::DATA_W-1:0] opnd_b = is_lit ? i_cmd.literal : i_file_rdata;

    logic [bal_pkg::DATA_W-1:0] add_sum;
    logic                       add_c;
    logic                       add_dc;

    bal_adder #(.W(bal_pkg::DATA_W)) u_add (
        .i_a          (acc),
        .i_b          (opnd_b),
        .o_sum        (add_sum),
        .o_carry      (add_c),
        .o_half_carry (add_dc)
    );

    wire logic [bal_pkg::DATA_W-1:0] and_res = acc & opnd_b;
    // Sign bit kept, bit 0 leaves through carry
    wire logic [bal_pkg::DATA_W-1:0] asr_res =
        {i_file_rdata[bal_pkg::MSB], i_file_rdata[bal_pkg::MSB:1]};

    // Signed literal widened to pointer width
    wire logic [bal_pkg::PTR_W-1:0] lit_ext =
        {{(bal_pkg::PTR_W-bal_pkg::LIT6_W){i_cmd.literal[bal_pkg::LIT6_W-1]}},
         i_cmd.literal[bal_pkg::LIT6_W-1:0]};
    // Carry out of the top dropped on purpose
    wire logic [bal_pkg::PTR_W-1:0] ptr_sum = ptr[i_cmd.ptr_sel] + lit_ext;

    logic [bal_pkg::DATA_W-1:0] res;
    logic                       upd_z;
    logic                       upd_c;
    logic                       upd_dc;
    logic                       new_c;
    logic                       to_file;
    logic                       writes;

    always_comb begin
        res    = and_res;
        upd_z  = 1'b0;
        upd_c  = 1'b0;
        upd_dc = 1'b0;
        new_c  = add_c;
        writes = 1'b1;
        case (op)
            bal_pkg::BAL_OP_LITERAL_AND,
            bal_pkg::BAL_OP_REGISTER_AND: begin
                res   = and_res;
                upd_z = 1'b1;
            end
            bal_pkg::BAL_OP_LITERAL_ADD,
            bal_pkg::BAL_OP_REGISTER_ADD: begin
                res    = add_sum;
                upd_z  = 1'b1;
                upd_c  = 1'b1;
                upd_dc = 1'b1;
            end
            bal_pkg::BAL_OP_ARITH_SHIFT: begin
                res   = asr_res;
                new_c = i_file_rdata[0];
                upd_z = 1'b1;
                upd_c = 1'b1;
            end
            default: begin
                writes = 1'b0;
            end
        endcase
    end

    // Literal ops always land in the accumulator
    assign to_file = writes && !is_lit && i_cmd.dest;

    wire logic res_zero = (res == '0);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            acc   <= bal_pkg::ACC_RST;
            flags <= '0;
        end else begin
            if (writes && !to_file) begin
                acc <= res;
            end
            if (upd_z) begin
                flags.z <= res_zero;
            end
            if (upd_c) begin
                flags.c <= new_c;
            end
            if (upd_dc) begin
                flags.dc <= add_dc;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ptr[0] <= bal_pkg::PTR_RST;
            ptr[1] <= bal_pkg::PTR_RST;
        end else if (op == bal_pkg::BAL_OP_POINTER_ADD) begin
            ptr[i_cmd.ptr_sel] <= ptr_sum;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            file_we    <= 1'b0;
            file_waddr <= '0;
            file_wdata <= '0;
        end else begin
            file_we <= to_file;
            if (to_file) begin
                file_waddr <= i_cmd.faddr;
                file_wdata <= res;
            end
        end
    end

    assign o_file_we    = file_we;
    assign o_file_waddr = file_waddr;
    assign o_file_wdata = file_wdata;
    assign o_acc        = acc;
    assign o_flags      = flags;
    assign o_ptr0       = ptr[0];
    assign o_ptr1       = ptr[1];
endmodule

// >>> bench/bal_alu_asserts.sv
module bal_alu_asserts (
    // Inputs
    input wire logic               i_sys_clk,
    input wire logic               i_rst,
    input wire logic               i_valid,
    input wire bal_pkg::bal_cmd_t  i_cmd,
    input wire logic [7:0]         i_file_rdata,
    // Outputs
    input wire logic               o_file_we,
    input wire logic [6:0]         o_file_waddr,
    input wire logic [7:0]         o_file_wdata,
    input wire logic [7:0]         o_acc,
    input wire bal_pkg::bal_flags_t o_flags,
    input wire logic [15:0]        o_ptr0,
    input wire logic [15:0]        o_ptr1
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    wire bal_pkg::bal_op_t op = i_cmd.op;
    wire logic [15:0] k = {{10{i_cmd.literal[5]}}, i_cmd.literal[5:0]};
    wire logic reg_op = i_valid && op >= bal_pkg::BAL_OP_REGISTER_AND;
    sequence s_ptr;
        i_valid && op == bal_pkg::BAL_OP_POINTER_ADD;
    endsequence
    ptr0_add_a: assert property (s_ptr ##0 !i_cmd.ptr_sel |=> o_ptr0 == $past(o_ptr0 + k)
        && $stable(o_ptr1) && $stable(o_flags)) else $error("pointer 0 add wrong");
    ptr1_add_a: assert property (s_ptr ##0 i_cmd.ptr_sel |=> o_ptr1 == $past(o_ptr1 + k)
        && $stable(o_ptr0)) else $error("pointer 1 add wrong");
    ptr_keep_a: assert property (i_valid && op != bal_pkg::BAL_OP_POINTER_ADD |=>
        $stable(o_ptr0) && $stable(o_ptr1)) else $error("pointer changed");
    lit_and_a: assert property (i_valid && op == bal_pkg::BAL_OP_LITERAL_AND |=>
        o_acc == $past(o_acc & i_cmd.literal) && o_flags.z == (o_acc == 8'h00)
        && $stable(o_flags.c) && $stable(o_flags.dc)) else $error("literal and wrong");
    lit_add_a: assert property (i_valid && op == bal_pkg::BAL_OP_LITERAL_ADD |=>
        {o_flags.c, o_acc} == $past({1'b0, o_acc} + i_cmd.literal) && o_flags.dc ==
        $past(({1'b0, o_acc[3:0]} + i_cmd.literal[3:0]) > 5'h0f)) else $error("literal add wrong");
    wr_dest_a: assert property (reg_op && i_cmd.dest |=> o_file_we
        && o_file_waddr == $past(i_cmd.faddr) && $stable(o_acc)) else $error("write back wrong");
    no_write_a: assert property (!(reg_op && i_cmd.dest) |=> !o_file_we)
        else $error("stray write");
    reg_and_a: assert property (i_valid && op == bal_pkg::BAL_OP_REGISTER_AND && !i_cmd.dest |=>
        o_acc == $past(o_acc & i_file_rdata) && $stable(o_flags.c))
        else $error("register and wrong");
    reg_add_a: assert property (i_valid && op == bal_pkg::BAL_OP_REGISTER_ADD && i_cmd.dest |=>
        o_file_wdata == $past(o_acc + i_file_rdata) && o_flags.z == (o_file_wdata == 8'h00))
        else $error("register add wrong");
    shift_a: assert property (i_valid && op == bal_pkg::BAL_OP_ARITH_SHIFT && !i_cmd.dest |=>
        o_acc == $past({i_file_rdata[7], i_file_rdata[7:1]}) && o_flags.c == $past(i_file_rdata[0]))
        else $error("shift wrong");
endmodule
bind bal_alu bal_alu_asserts u_bal_alu_asserts (.*);

// >>> bench/byte_alu_add_and_shift_ops_bench.sv
module byte_alu_add_and_shift_ops_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_sys_clk = 0, i_rst = 1, i_valid = 0, o_file_we, we;
    bal_pkg::bal_cmd_t   i_cmd = '0, c;
    bal_pkg::bal_flags_t o_flags, f;
    logic [7:0]  i_file_rdata = 8'h00, o_file_wdata, o_acc, a, b, wd;
    logic [6:0]  o_file_waddr, wa;
    logic [15:0] o_ptr0, o_ptr1, p0, p1, k;
    logic [8:0]  s;
    logic [58:0] q[$];
    int fail_count = 0, cmp_count = 0, seed = 83;
    always #25 i_sys_clk = ~i_sys_clk;
    bal_alu u_bal_alu (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_valid(i_valid), .i_cmd(i_cmd),
        .i_file_rdata(i_file_rdata), .o_file_we(o_file_we), .o_file_waddr(o_file_waddr),
        .o_file_wdata(o_file_wdata), .o_acc(o_acc), .o_flags(o_flags), .o_ptr0(o_ptr0),
        .o_ptr1(o_ptr1));
    task check(input string n, input logic [58:0] seen, input logic [58:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task test_done;
        if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog well past the 504 cycles of stimulus
    initial begin
        #40000;
        fail_count++;
        test_done;
    end
    always @(posedge i_sys_clk) begin
        #1;
        if (q.size() > 0)
            check("state", {o_acc, o_flags, o_ptr0, o_ptr1, o_file_we, o_file_wdata, o_file_waddr},
                q.pop_front());
    end
    initial begin
        {a, f, p0, p1, wd, wa} = '0;
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 0;
        repeat (500) begin
            @(posedge i_sys_clk);
            we = 0;
            k = {{10{i_cmd.literal[5]}}, i_cmd.literal[5:0]};
            b = (i_cmd.op < bal_pkg::BAL_OP_REGISTER_AND) ? i_cmd.literal : i_file_rdata;
            if (i_valid) begin
                case (i_cmd.op)
                    bal_pkg::BAL_OP_POINTER_ADD: if (i_cmd.ptr_sel) p1 += k; else p0 += k;
                    bal_pkg::BAL_OP_LITERAL_AND, bal_pkg::BAL_OP_REGISTER_AND: s = a & b;
                    bal_pkg::BAL_OP_ARITH_SHIFT: s = {b[0], b[7], b[7:1]};
                    bal_pkg::BAL_OP_LITERAL_ADD, bal_pkg::BAL_OP_REGISTER_ADD: begin
                        s = a + b;
                        f.dc = ({1'b0, a[3:0]} + b[3:0]) > 5'h0f;
                    end
                    default: ;
                endcase
                if (i_cmd.op >= bal_pkg::BAL_OP_LITERAL_AND) begin
                    f.z = s[7:0] == 8'h00;
                    if (i_cmd.op != bal_pkg::BAL_OP_LITERAL_AND && i_cmd.op != bal_pkg::BAL_OP_REGISTER_AND)
                        f.c = s[8];
                    we = i_cmd.op >= bal_pkg::BAL_OP_REGISTER_AND && i_cmd.dest;
                    if (we) {wd, wa} = {s[7:0], i_cmd.faddr};
                    else a = s[7:0];
                end
            end
            q.push_back({a, f, p0, p1, we, wd, wa});
            c = $random(seed);
            c.op = bal_pkg::bal_op_t'($unsigned($random(seed)) % 7);
            i_cmd <= c;
            i_valid <= $random(seed);
            i_file_rdata <= $random(seed);
        end
        test_done;
    end
endmodule
